// ===== logic/rcc_cfg.svh
/*
 * Constants of the embedded control core: memory sizes, address map,
 * instruction fields and side bus timing.
 * Assumes a single 20 MHz system clock.
 */
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH

// ----------------------------------------------------------------------
// Clock and side bus timing
// ----------------------------------------------------------------------
`define RCC_CLK_NS        50
`define RCC_STROBE_NS     150
`define RCC_STROBE_CYC    ((`RCC_STROBE_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)

// ----------------------------------------------------------------------
// Memories and address map
// ----------------------------------------------------------------------
`define RCC_IRAM_WORDS    4608
`define RCC_DM_WORDS      512
`define RCC_RESET_PC      13'h0000
`define RCC_REG_TOP       21'h0001ff
`define RCC_DM_TOP        21'h0003ff
`define RCC_VECTOR_ACKNOWLEDGE_REGISTER_ADDR     9'h020
`define RCC_BOOT_BYTES    16'h3600

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define RCC_F_OP_HI       21
`define RCC_F_OP_LO       17
`define RCC_F_A_HI        16
`define RCC_F_A_LO        12
`define RCC_F_B_HI        11
`define RCC_F_B_LO        7
`define RCC_F_C_HI        6
`define RCC_F_C_LO        2
`define RCC_F_IMM_HI      11

`endif

// ===== logic/rcc_pkg.sv
/*
 * Types shared by the control core, its arithmetic unit and its loader.
 * Assumes rcc_cfg.svh for the numeric constants.
 */
package rcc_pkg;

    typedef enum logic [4:0] {
        RCC_OP_NOP, RCC_OP_ADD, RCC_OP_SUB, RCC_OP_AND, RCC_OP_OR,
        RCC_OP_XOR, RCC_OP_MUL, RCC_OP_DIV, RCC_OP_LDI, RCC_OP_LD,
        RCC_OP_ST, RCC_OP_SEGS, RCC_OP_JMP, RCC_OP_BEQZ, RCC_OP_EI,
        RCC_OP_RET
    } rcc_op_type;

    typedef enum logic [1:0] {
        RCC_BOOT_IDLE, RCC_BOOT_STROBE, RCC_BOOT_WRITE, RCC_BOOT_DONE
    } rcc_boot_state_type;

endpackage : rcc_pkg

// ===== logic/rcc_alu.sv
/*
 * 16-bit arithmetic unit of the control core, purely combinational.
 * Assumes operands already forwarded by the execute stage.
 */
`timescale 1ns/10ps
`default_nettype none

module rcc_alu
    import rcc_pkg::*;
(
    input  wire logic [4:0]  op,
    input  wire logic [15:0] opa,
    input  wire logic [15:0] opb,
    input  wire logic [11:0] imm,
    output logic      [15:0] result
);
    wire logic [31:0] product = opa * opb;
    // Division by zero yields all ones instead of an undefined quotient
    wire logic [15:0] quotient = (opb == 16'h0000) ? 16'hffff : opa / opb;

    always_comb begin
        unique case (rcc_op_type'(op))
            RCC_OP_ADD: result = opa + opb;
            RCC_OP_SUB: result = opa - opb;
            RCC_OP_AND: result = opa & opb;
            RCC_OP_OR:  result = opa | opb;
            RCC_OP_XOR: result = opa ^ opb;
            RCC_OP_MUL: result = product[15:0];
            RCC_OP_DIV: result = quotient;
            RCC_OP_LDI: result = {4'h0, imm};
            default:    result = 16'h0000;
        endcase
    end
endmodule : rcc_alu

`default_nettype wire

// ===== logic/rcc_boot_loader.sv
/*
 * Side bus firmware loader: reads three bytes per instruction word from
 * the boot ROM and writes the words into the instruction RAM.
 * Assumes the ROM answers within one read strobe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rcc_cfg.svh"

module rcc_boot_loader
    import rcc_pkg::*;
#(
    parameter int IRAM_WORDS = `RCC_IRAM_WORDS
)(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        boot_load_strap_n,
    input  wire logic [7:0]  side_data_in,
    output logic      [15:0] side_address_bus,
    output logic             side_io_read_strobe_n,
    output logic             side_io_write_strobe_n,
    output logic      [7:0]  side_data_out,
    output logic             side_data_oe,
    output logic             boot_rom_select_n,
    output logic             busy,
    output logic             iram_we,
    output logic      [12:0] iram_addr,
    output logic      [21:0] iram_wdata
);
    localparam logic [2:0] STROBE_LAST = 3'(`RCC_STROBE_CYC - 1);

    if (IRAM_WORDS * 3 > 65536 || IRAM_WORDS > 8192) begin : g_size_check
        $error("rcc_boot_loader: image does not fit the side bus");
    end

    rcc_boot_state_type state;
    logic        strap_seen;
    logic [2:0]  cnt;
    logic [1:0]  byte_sel;
    logic [15:0] word_lo;

    wire logic last_word = (iram_addr == 13'(IRAM_WORDS - 1));

    // Loader never writes the ROM, so the data pins stay released
    assign side_io_write_strobe_n = 1'b1;
    assign side_data_out          = 8'h00;
    assign side_data_oe           = 1'b0;
    assign busy = (state == RCC_BOOT_STROBE) || (state == RCC_BOOT_WRITE);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state                 <= RCC_BOOT_IDLE;
            strap_seen            <= 1'b0;
            cnt                   <= 3'h0;
            byte_sel              <= 2'h0;
            word_lo               <= 16'h0000;
            side_address_bus      <= 16'h0000;
            side_io_read_strobe_n <= 1'b1;
            boot_rom_select_n     <= 1'b1;
            iram_we               <= 1'b0;
            iram_addr             <= 13'h0000;
            iram_wdata            <= 22'h000000;
        end else begin
            iram_we <= 1'b0;
            unique case (state)
                RCC_BOOT_IDLE: begin
                    strap_seen <= 1'b1;
                    // Strap is caught once, first edge after reset release
                    if (!strap_seen && !boot_load_strap_n) begin
                        state                 <= RCC_BOOT_STROBE;
                        side_io_read_strobe_n <= 1'b0;
                        boot_rom_select_n     <= 1'b0;
                    end
                end
                RCC_BOOT_STROBE: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == STROBE_LAST) begin
                        cnt                   <= 3'h0;
                        side_io_read_strobe_n <= 1'b1;
                        side_address_bus      <= side_address_bus + 16'h0001;
                        byte_sel              <= byte_sel + 2'h1;
                        if (byte_sel == 2'h0)
                            word_lo[7:0] <= side_data_in;
                        if (byte_sel == 2'h1)
                            word_lo[15:8] <= side_data_in;
                        if (byte_sel == 2'h2) begin
                            byte_sel   <= 2'h0;
                            iram_wdata <= {side_data_in[5:0], word_lo};
                            iram_we    <= 1'b1;
                        end
                        state <= RCC_BOOT_WRITE;
                    end
                end
                RCC_BOOT_WRITE: begin
                    if (iram_we) begin
                        iram_addr <= iram_addr + 13'h0001;
                    end
                    if (iram_we && last_word) begin
                        state             <= RCC_BOOT_DONE;
                        boot_rom_select_n <= 1'b1;
                    end else begin
                        state                 <= RCC_BOOT_STROBE;
                        side_io_read_strobe_n <= 1'b0;
                    end
                end
                RCC_BOOT_DONE: begin
                    boot_rom_select_n <= 1'b1;
                end
            endcase
        end
    end
endmodule : rcc_boot_loader

`default_nettype wire

// ===== logic/rcc_core.sv
/*
 * Embedded control core: four-stage pipeline, register file, data RAM,
 * instruction RAM, data address decode, interrupts, loader hookup.
 * Assumes the host or the boot ROM loads firmware and DRAM answers dram_req with ack.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rcc_cfg.svh"

module rcc_core
    import rcc_pkg::*;
#(
    parameter int IRAM_WORDS = `RCC_IRAM_WORDS,
    parameter int DM_WORDS   = `RCC_DM_WORDS
)(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        core_enable,
    input  wire logic        host_iram_we,
    input  wire logic [12:0] host_iram_addr,
    input  wire logic [21:0] host_iram_wdata,
    input  wire logic        boot_load_strap_n,
    input  wire logic [7:0]  side_data_in,
    output logic      [7:0]  side_data_out,
    output logic             side_data_oe,
    output logic      [15:0] side_address_bus,
    output logic             side_io_read_strobe_n,
    output logic             side_io_write_strobe_n,
    output logic             boot_rom_select_n,
    output logic             boot_busy,
    output logic             running,
    input  wire logic [30:0] int_req,
    output logic             int_ack,
    output logic      [4:0]  int_ack_vec,
    output logic             dram_req,
    output logic             dram_we,
    output logic      [20:0] dram_addr,
    output logic      [15:0] dram_wdata,
    input  wire logic [15:0] dram_rdata,
    input  wire logic        dram_ack
);
    // Write address is 13 bits, so 8192 words would defeat the range test
    if (IRAM_WORDS < 32 || IRAM_WORDS > 8191 || DM_WORDS != 512) begin : g_size_check
        $error("rcc_core: memory sizes not supported");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] first_req(input logic [30:0] req);
        first_req = 5'h00;
        for (int i = 30; i >= 0; i--) begin
            if (req[i])
                first_req = 5'(i + 1);
        end
    endfunction : first_req

    function automatic logic is_mem(input logic [4:0] op);
        is_mem = (op == RCC_OP_LD) || (op == RCC_OP_ST);
    endfunction : is_mem

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [21:0] iram [IRAM_WORDS];
    logic [15:0] dm   [DM_WORDS];
    logic [15:0] regs [32];

    // ------------------------------------------------------------------
    // Loader and instruction RAM write port
    // ------------------------------------------------------------------
    logic        ld_we;
    logic [12:0] ld_addr;
    logic [21:0] ld_wdata;

    rcc_boot_loader #(
        .IRAM_WORDS             (IRAM_WORDS)
    ) u_loader (
        .clk_sys                (clk_sys),
        .srst                   (srst),
        .boot_load_strap_n      (boot_load_strap_n),
        .side_data_in           (side_data_in),
        .side_address_bus       (side_address_bus),
        .side_io_read_strobe_n  (side_io_read_strobe_n),
        .side_io_write_strobe_n (side_io_write_strobe_n),
        .side_data_out          (side_data_out),
        .side_data_oe           (side_data_oe),
        .boot_rom_select_n      (boot_rom_select_n),
        .busy                   (boot_busy),
        .iram_we                (ld_we),
        .iram_addr              (ld_addr),
        .iram_wdata             (ld_wdata)
    );

    // Loader owns the port while busy; host writes are dropped then
    wire logic        iram_we    = ld_we | (host_iram_we & ~boot_busy);
    wire logic [12:0] iram_waddr = ld_we ? ld_addr : host_iram_addr;
    wire logic [21:0] iram_wdat  = ld_we ? ld_wdata : host_iram_wdata;

    always_ff @(posedge clk_sys) begin
        if (iram_we && iram_waddr < 13'(IRAM_WORDS))
            iram[iram_waddr] <= iram_wdat;
    end

    // ------------------------------------------------------------------
    // Pipeline registers
    // ------------------------------------------------------------------
    logic [12:0] pc;
    logic        dec_valid;
    logic [21:0] dec_instr;
    logic [12:0] dec_pc;
    logic        exe_valid;
    logic [4:0]  exe_op;
    logic [4:0]  exe_rd;
    logic [15:0] exe_a;
    logic [15:0] exe_b;
    logic [12:0] exe_imm;
    logic        wb_we;
    logic [4:0]  wb_rd;
    logic [15:0] wb_data;
    logic [4:0]  segment;
    logic        int_en;
    logic [12:0] shadow_pc;
    logic [4:0]  cur_vec;

    assign running = core_enable & ~boot_busy;

    // ------------------------------------------------------------------
    // Decode stage
    // ------------------------------------------------------------------
    wire logic [4:0]  d_op  = dec_instr[`RCC_F_OP_HI:`RCC_F_OP_LO];
    wire logic [4:0]  d_fa  = dec_instr[`RCC_F_A_HI:`RCC_F_A_LO];
    wire logic [4:0]  d_fb  = dec_instr[`RCC_F_B_HI:`RCC_F_B_LO];
    wire logic [4:0]  d_fc  = dec_instr[`RCC_F_C_HI:`RCC_F_C_LO];
    wire logic [12:0] d_imm = {1'b0, dec_instr[`RCC_F_IMM_HI:0]};
    wire logic        d_a_src = (d_op == RCC_OP_ST) || (d_op == RCC_OP_BEQZ);
    wire logic [4:0]  d_rs1 = d_fb;
    wire logic [4:0]  d_rs2 = d_a_src ? d_fa : d_fc;
    wire logic        d_wr  = (d_op <= RCC_OP_LD) && (d_op != RCC_OP_NOP);

    // ------------------------------------------------------------------
    // Execute stage and data address decode
    // ------------------------------------------------------------------
    logic [15:0] alu_res;

    rcc_alu u_alu (
        .op     (exe_op),
        .opa    (exe_a),
        .opb    (exe_b),
        .imm    (exe_imm[11:0]),
        .result (alu_res)
    );

    wire logic [20:0] daddr   = {segment, exe_a};
    wire logic        e_mem   = exe_valid && is_mem(exe_op);
    wire logic        hit_reg = daddr <= `RCC_REG_TOP;
    wire logic        hit_dm  = !hit_reg && daddr <= `RCC_DM_TOP;
    wire logic        hit_ext = daddr > `RCC_DM_TOP;
    wire logic        hit_vec = hit_reg && daddr[8:0] == `RCC_VECTOR_ACKNOWLEDGE_REGISTER_ADDR;
    wire logic        e_load  = e_mem && exe_op == RCC_OP_LD;
    wire logic        stall   = e_mem && hit_ext && !dram_ack;
    wire logic        e_jump  = exe_valid && (exe_op == RCC_OP_JMP ||
                                (exe_op == RCC_OP_BEQZ && exe_b == 16'h0000));
    wire logic        e_ret   = exe_valid && exe_op == RCC_OP_RET;
    wire logic        redirect = e_jump || e_ret;
    wire logic [15:0] ld_data = hit_ext ? dram_rdata :
                                hit_dm  ? dm[daddr[8:0]] :
                                hit_vec ? {11'h000, cur_vec} : 16'h0000;
    wire logic [15:0] e_res   = e_load ? ld_data : alu_res;
    wire logic        e_wr    = exe_valid && exe_op <= RCC_OP_LD &&
                                exe_op != RCC_OP_NOP && !stall;

    assign dram_req   = e_mem && hit_ext;
    assign dram_we    = exe_op == RCC_OP_ST;
    assign dram_addr  = daddr;
    assign dram_wdata = exe_b;

    // Interrupt taken only when nothing is redirecting the pipe
    wire logic [4:0] pend_vec = first_req(int_req);
    wire logic       take_int = running && int_en && |int_req &&
                                !stall && !redirect;

    // ------------------------------------------------------------------
    // Register file with forwarding
    // ------------------------------------------------------------------
    wire logic [15:0] rf1 = (d_rs1 == 5'h00) ? 16'h0000 : regs[d_rs1];
    wire logic [15:0] rf2 = (d_rs2 == 5'h00) ? 16'h0000 : regs[d_rs2];
    wire logic        fw1 = e_wr && exe_rd == d_rs1 && d_rs1 != 5'h00;
    wire logic        fw2 = e_wr && exe_rd == d_rs2 && d_rs2 != 5'h00;
    // Write-back lands on the edge that latches decode, so bypass it too
    wire logic        wf1 = wb_we && wb_rd == d_rs1 && d_rs1 != 5'h00;
    wire logic        wf2 = wb_we && wb_rd == d_rs2 && d_rs2 != 5'h00;
    wire logic [15:0] src1 = fw1 ? e_res : wf1 ? wb_data : rf1;
    wire logic [15:0] src2 = fw2 ? e_res : wf2 ? wb_data : rf2;

    always_ff @(posedge clk_sys) begin
        if (wb_we && wb_rd != 5'h00)
            regs[wb_rd] <= wb_data;
    end

    always_ff @(posedge clk_sys) begin
        if (e_mem && hit_dm && exe_op == RCC_OP_ST)
            dm[daddr[8:0]] <= exe_b;
    end

    // ------------------------------------------------------------------
    // Fetch and program counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || !running) begin
            pc        <= `RCC_RESET_PC;
            dec_valid <= 1'b0;
            dec_instr <= 22'h000000;
            dec_pc    <= 13'h0000;
        end else if (!stall) begin
            dec_instr <= iram[pc];
            dec_pc    <= pc;
            dec_valid <= !redirect && !take_int;
            pc        <= pc + 13'h0001;
            if (e_ret)
                pc <= shadow_pc;
            else if (e_jump)
                pc <= exe_imm;
            else if (take_int)
                pc <= {8'h00, pend_vec};
        end
    end

    // ------------------------------------------------------------------
    // Decode to execute
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || !running) begin
            exe_valid <= 1'b0;
            exe_op    <= 5'h00;
            exe_rd    <= 5'h00;
            exe_a     <= 16'h0000;
            exe_b     <= 16'h0000;
            exe_imm   <= 13'h0000;
        end else if (!stall) begin
            exe_valid <= dec_valid && !redirect && !take_int;
            exe_op    <= d_op;
            exe_rd    <= d_wr ? d_fa : 5'h00;
            exe_a     <= src1;
            exe_b     <= src2;
            exe_imm   <= (d_op == RCC_OP_JMP) ? dec_instr[12:0] : d_imm;
        end
    end

    // ------------------------------------------------------------------
    // Execute to write-back, core state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || !running) begin
            wb_we     <= 1'b0;
            wb_rd     <= 5'h00;
            wb_data   <= 16'h0000;
            segment   <= 5'h00;
            int_en    <= 1'b0;
            shadow_pc <= 13'h0000;
            cur_vec   <= 5'h00;
        end else begin
            wb_we   <= e_wr;
            wb_rd   <= exe_rd;
            wb_data <= e_res;
            if (exe_valid && exe_op == RCC_OP_SEGS)
                segment <= exe_imm[4:0];
            if (exe_valid && exe_op == RCC_OP_EI)
                int_en <= 1'b1;
            if (take_int) begin
                int_en    <= 1'b0;
                shadow_pc <= dec_valid ? dec_pc : pc;
                cur_vec   <= pend_vec;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            int_ack     <= 1'b0;
            int_ack_vec <= 5'h00;
        end else begin
            int_ack     <= e_load && hit_vec;
            int_ack_vec <= cur_vec;
        end
    end
endmodule : rcc_core

`default_nettype wire

// ===== tb/rcc_core_sva.sv
/* Assertions on the ports of the control core.
   Assumes it is bound into every rcc_core instance. */
`timescale 1ns/10ps
`default_nettype none
module rcc_core_sva (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        boot_load_strap_n,
    input wire logic [15:0] side_address_bus,
    input wire logic        side_io_read_strobe_n,
    input wire logic        boot_rom_select_n,
    input wire logic        boot_busy,
    input wire logic        running,
    input wire logic        int_ack,
    input wire logic [4:0]  int_ack_vec,
    input wire logic        dram_req,
    input wire logic [20:0] dram_addr,
    input wire logic        dram_ack
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    dram_map_a: assert property (dram_req |-> dram_addr > 21'h0003ff)
        else $error("DRAM request inside internal region");
    dram_hold_a: assert property (dram_req && !dram_ack |=> dram_req && $stable(dram_addr))
        else $error("DRAM request dropped before acknowledge");
    strobe_len_a: assert property ($fell(side_io_read_strobe_n) |->
        !side_io_read_strobe_n [*3] ##1 side_io_read_strobe_n) else $error("Read strobe width wrong");
    addr_hold_a: assert property ($fell(side_io_read_strobe_n) |=> $stable(side_address_bus) [*2])
        else $error("Side address moved under strobe");
    read_sel_a: assert property (!side_io_read_strobe_n |-> !boot_rom_select_n && boot_busy)
        else $error("Read strobe without ROM select");
    load_halt_a: assert property (boot_busy |-> !running && !dram_req && !int_ack)
        else $error("Core active during firmware load");
    boot_start_a: assert property ($rose(boot_busy) |-> !$past(boot_load_strap_n))
        else $error("Firmware load without strap");
    ack_pulse_a: assert property (int_ack |-> int_ack_vec != 5'h00 ##1 !int_ack)
        else $error("Vector acknowledge malformed");
endmodule : rcc_core_sva
bind rcc_core rcc_core_sva chk (.clk_sys(clk_sys), .srst(srst), .boot_load_strap_n(boot_load_strap_n),
    .side_address_bus(side_address_bus), .side_io_read_strobe_n(side_io_read_strobe_n),
    .boot_rom_select_n(boot_rom_select_n), .boot_busy(boot_busy), .running(running), .int_ack(int_ack),
    .int_ack_vec(int_ack_vec), .dram_req(dram_req), .dram_addr(dram_addr), .dram_ack(dram_ack));
`default_nettype wire

// ===== tb/rcc_boot_rom.sv
/* Boot ROM model on the side bus: 64-word image, slow read access.
   Assumes the testbench fills img before the loader starts. */
`timescale 1ns/10ps
`default_nettype none
module rcc_boot_rom #(
    parameter int ACCESS_CYC = 2
)(
    input  wire logic        clk_sys,
    input  wire logic        select_n,
    input  wire logic        read_n,
    input  wire logic [15:0] addr,
    output logic      [7:0]  data
);
    logic [21:0] img [0:63];
    logic [21:0] word;
    logic [7:0]  cur;
    logic [7:0]  last = 8'ha5;
    int          low_cnt = 0;
    wire logic   drive = !select_n && !read_n && low_cnt >= ACCESS_CYC;
    assign word = (addr / 3 < 64) ? img[addr / 3] : 22'h000000;
    // Top bits of the third byte are junk that the loader must drop
    assign cur = (addr % 3 == 0) ? word[7:0] : (addr % 3 == 1) ? word[15:8] : {2'b11, word[21:16]};
    // Released bus shows the inverse of the last byte
    assign data = drive ? cur : ~last;
    always @(posedge clk_sys) begin
        low_cnt <= (!select_n && !read_n) ? low_cnt + 1 : 0;
        if (drive) last <= cur;
    end
endmodule : rcc_boot_rom
`default_nettype wire

// ===== tb/rcc_core_test.sv
/* Testbench of the control core: ROM boot load, host load, program run.
   Assumes rcc_core, rcc_boot_rom and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module rcc_core_test
    import rcc_pkg::*;
;
    logic        clk_sys, srst, core_enable, host_iram_we, strap_n, rd_n, sel_n, wr_n, oe;
    logic        boot_busy, running, int_ack, dram_req, dram_we, dram_ack;
    logic [12:0] host_iram_addr;
    logic [21:0] host_iram_wdata;
    logic [7:0]  side_data_in, dout;
    logic [15:0] side_address_bus, dram_wdata, dram_rdata;
    logic [30:0] int_req;
    logic [4:0]  int_ack_vec;
    logic [20:0] dram_addr;
    logic [21:0] prog [0:63];
    logic [37:0] dq [$];
    int          num_errors, n_tests;
    rcc_core DUT (.clk_sys(clk_sys), .srst(srst), .core_enable(core_enable), .host_iram_we(host_iram_we),
        .host_iram_addr(host_iram_addr), .host_iram_wdata(host_iram_wdata), .boot_load_strap_n(strap_n),
        .side_data_in(side_data_in), .side_data_out(dout), .side_data_oe(oe), .side_address_bus(side_address_bus),
        .side_io_read_strobe_n(rd_n), .side_io_write_strobe_n(wr_n), .boot_rom_select_n(sel_n),
        .boot_busy(boot_busy), .running(running), .int_req(int_req), .int_ack(int_ack),
        .int_ack_vec(int_ack_vec), .dram_req(dram_req), .dram_we(dram_we), .dram_addr(dram_addr),
        .dram_wdata(dram_wdata), .dram_rdata(dram_rdata), .dram_ack(dram_ack));
    rcc_boot_rom rom (.clk_sys(clk_sys), .select_n(sel_n), .read_n(rd_n), .addr(side_address_bus),
        .data(side_data_in));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // DRAM side: log each acknowledged transfer, acknowledge in the request's own cycle but never two cycles in a row
    assign dram_rdata = dram_ack ? 16'h1357 : 16'heca8;
    always @(posedge clk_sys) begin
        if (dram_req && dram_ack) dq.push_back({dram_we, dram_addr, dram_wdata});
        #1 dram_ack = dram_req && !dram_ack;
    end
    function automatic logic [21:0] w(input rcc_op_type op, input logic [4:0] a, input logic [11:0] lo);
        return {op, a, lo};
    endfunction : w
    task automatic chk(input logic [37:0] got, input logic [37:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic do_reset(input logic strap, input logic en);
        srst = 1'b1;
        strap_n = strap;
        core_enable = en;
        cyc(16);
        srst = 1'b0;
        dq.delete();
    endtask : do_reset
    task automatic run_check;
        int i;
        int acks;
        acks = 0;
        int_req = 31'h00000001;
        for (i = 0; i < 3000 && int_ack !== 1'b1; i++) cyc(1);
        chk({int_ack, int_ack_vec}, 6'h21);
        chk(dq.size(), 2);
        if (dq.size() == 2) begin
            chk(dq[0], {1'b1, 21'h010234, 16'hda90});
            chk(dq[1][37:16], {1'b0, 21'h010234});
        end
        for (i = 0; i < 40; i++) begin
            cyc(1);
            if (int_ack !== 1'b0) acks++;
        end
        chk(acks, 0);
        int_req = 31'h00000000;
    endtask : run_check
    task automatic test_boot;
        int i;
        do_reset(1'b0, 1'b1);
        cyc(4);
        chk({boot_busy, sel_n, running, wr_n, oe, dout}, {5'b10010, 8'h00});
        for (i = 0; i < 60000 && boot_busy !== 1'b0; i++) cyc(1);
        chk({boot_busy, sel_n, running}, 3'b011);
        run_check();
        $display("test_boot done");
    endtask : test_boot
    task automatic test_host;
        int i;
        do_reset(1'b1, 1'b0);
        cyc(2);
        chk({boot_busy, sel_n}, 2'b01);
        for (i = 0; i < 45; i++) begin
            host_iram_we = 1'b1;
            host_iram_addr = 13'(i);
            host_iram_wdata = prog[i];
            cyc(1);
        end
        host_iram_we = 1'b0;
        core_enable = 1'b1;
        run_check();
        core_enable = 1'b0;
        cyc(2);
        dq.delete();
        core_enable = 1'b1;
        run_check();
        $display("test_host done");
    endtask : test_host
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {srst, core_enable, host_iram_we, strap_n, dram_ack} = 5'b10010;
        host_iram_addr = 13'h0000;
        host_iram_wdata = 22'h000000;
        int_req = 31'h00000000;
        num_errors = 0;
        n_tests = 0;
        for (int k = 0; k < 64; k++) prog[k] = 22'h000000;
        prog[0] = w(RCC_OP_JMP, 5'd0, 12'h020);
        prog[1] = w(RCC_OP_LD, 5'd2, {5'd3, 7'h00});
        prog[2] = w(RCC_OP_JMP, 5'd0, 12'h002);
        prog[32] = w(RCC_OP_LDI, 5'd3, 12'h020);
        prog[33] = w(RCC_OP_LDI, 5'd1, 12'h234);
        prog[34] = w(RCC_OP_LDI, 5'd5, 12'h3ff);
        prog[35] = w(RCC_OP_ST, 5'd1, {5'd5, 7'h00});
        prog[36] = w(RCC_OP_ST, 5'd1, {5'd0, 7'h00});
        prog[37] = w(RCC_OP_LD, 5'd6, {5'd5, 7'h00});
        prog[38] = w(RCC_OP_MUL, 5'd7, {5'd6, 5'd1, 2'b00});
        prog[39] = w(RCC_OP_SEGS, 5'd0, 12'h001);
        prog[40] = w(RCC_OP_ST, 5'd7, {5'd1, 7'h00});
        prog[41] = w(RCC_OP_LD, 5'd8, {5'd1, 7'h00});
        prog[42] = w(RCC_OP_SEGS, 5'd0, 12'h000);
        prog[43] = w(RCC_OP_EI, 5'd0, 12'h000);
        prog[44] = w(RCC_OP_JMP, 5'd0, 12'h02c);
        rom.img = prog;
        test_boot();
        test_host();
        report_and_stop();
    end
    initial begin
        #(70000 * 50);
        num_errors++;
        report_and_stop();
    end
endmodule : rcc_core_test
`default_nettype wire
